//--- rtl/rpcg_clock_gate.sv
// Run-mode peripheral clock gate register with AHB-Lite slave and glitch-free unit clocks.
`timescale 1ns/1ps
`default_nettype none
module rpcg_clock_gate
  import rpcg_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [rpcg_pkg::RPCG_NUM_UNITS-1:0] unitAccess,
  output logic unitFault,
  output logic unitGrant,
  output logic [rpcg_pkg::RPCG_NUM_UNITS-1:0] unitClkEn,
  output logic [rpcg_pkg::RPCG_NUM_UNITS-1:0] unitClk
);
  import rpcg_pkg::*;

  // The decoder compares against a 32-bit offset, so wider buses are refused as well.
  if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 9 and 32");
  end

  // Unit order, high to low: counters 3..0, two-wire 1..0, encoder 1..0, sync 1..0, async 2..0.
  function automatic logic [RPCG_NUM_UNITS-1:0] unitsOf(input logic [31:0] r);
    unitsOf = {r[RPCG_COUNTER3_BIT:RPCG_COUNTER0_BIT], r[RPCG_TWOWIRE1_BIT], r[RPCG_TWOWIRE0_BIT],
      r[RPCG_ENCODER1_BIT], r[RPCG_ENCODER0_BIT], r[RPCG_SYNC1_BIT], r[RPCG_SYNC0_BIT],
      r[RPCG_ASYNC2_BIT:RPCG_ASYNC0_BIT]};
  endfunction

  logic [31:0] gateReg;
  logic [31:0] next_gateReg;
  logic [RPCG_NUM_UNITS-1:0] next_units;
  logic [RPCG_NUM_UNITS-1:0] enLow;
  rpcg_aphase_t aphase;
  rpcg_aphase_t next_aphase;

  wire logic takeAddr = hsel && hready && htrans == RPCG_HTRANS_NONSEQ;
  wire logic addrHit = haddr == RPCG_GATE_OFFSET[ADDR_W-1:0];
  wire logic doWrite = aphase.active && aphase.write && aphase.hit;
  wire logic doRead = takeAddr && !hwrite && addrHit;

  assign next_aphase = '{active: takeAddr, write: hwrite, hit: addrHit};
  // Masking the write keeps reserved bits at zero whatever software sends.
  assign next_gateReg = doWrite ? (hwdata & RPCG_GATE_WMASK) : gateReg;
  assign next_units = unitsOf(next_gateReg);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      gateReg <= RPCG_GATE_RESET;
      aphase <= '0;
      hreadyout <= 1'b1;
      hresp <= RPCG_HRESP_OKAY;
      hrdata <= 32'h0000_0000;
    end else begin
      gateReg <= next_gateReg;
      aphase <= next_aphase;
      hreadyout <= 1'b1;
      hresp <= RPCG_HRESP_OKAY;
      // Forwarding the pending write lets a read follow a write back to back.
      hrdata <= doRead ? next_gateReg : 32'h0000_0000;
    end
  end

  // An access that touches any unclocked unit is faulted, never also granted.
  wire logic anyGated = |(unitAccess & ~unitClkEn);
  wire logic anyOpen = unitAccess != '0 && !anyGated;

  // Enables load from the next gate value, so they switch with gateReg; the fault answer uses the current enables.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      unitClkEn <= '0;
      unitFault <= 1'b0;
      unitGrant <= 1'b0;
    end else begin
      unitClkEn <= next_units;
      unitFault <= anyGated;
      unitGrant <= anyOpen;
    end
  end

  // The enable is retimed on the falling edge, so the AND only changes while mclk is low.
  always_ff @(negedge mclk) begin
    if (!rst_b) begin
      enLow <= '0;
    end else begin
      enLow <= unitClkEn;
    end
  end

  assign unitClk = {RPCG_NUM_UNITS{mclk}} & enLow;

  // Bus side: the register answers at once, masks reserved bits and ignores other offsets.
  a_reserved_zero: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (gateReg & ~RPCG_GATE_WMASK) == 32'h0000_0000 &&
      (hrdata & ~RPCG_GATE_WMASK) == 32'h0000_0000
  ) else $error("reserved gate bits not zero");

  a_write_lands: assert property (
    @(posedge mclk) disable iff (!rst_b)
    doWrite |=> gateReg == ($past(hwdata) & RPCG_GATE_WMASK)
  ) else $error("gate write did not land");

  a_write_ignored: assert property (
    @(posedge mclk) disable iff (!rst_b)
    aphase.active && aphase.write && !aphase.hit |=> $stable(gateReg)
  ) else $error("write to another offset changed the gate bits");

  a_read_returns: assert property (
    @(posedge mclk) disable iff (!rst_b)
    doRead |=> hrdata == gateReg
  ) else $error("gate read returned wrong value");

  a_unmapped_zero: assert property (
    @(posedge mclk) disable iff (!rst_b)
    takeAddr && !hwrite && !addrHit |=> hrdata == 32'h0000_0000
  ) else $error("read of another offset not zero");

  // Read data stands for the data phase only, so a stale word never leaks onto the bus.
  a_idle_rdata: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !doRead |=> hrdata == 32'h0000_0000
  ) else $error("read data outside a read");

  a_zero_wait: assert property (
    @(posedge mclk) disable iff (!rst_b)
    takeAddr |=> hreadyout && hresp == RPCG_HRESP_OKAY
  ) else $error("slave stalled or errored");

  a_gate_hold: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !doWrite |=> $stable(gateReg)
  ) else $error("gate bits changed without write");

  // Unit side: each enable sits on the bit that gates its unit.
  a_enable_map: assert property (
    @(posedge mclk) disable iff (!rst_b)
    unitClkEn[12:9] == gateReg[RPCG_COUNTER3_BIT:RPCG_COUNTER0_BIT]
  ) else $error("counter enables not on their gate bits");

  a_twowire_map: assert property (
    @(posedge mclk) disable iff (!rst_b)
    unitClkEn[8:7] == {gateReg[RPCG_TWOWIRE1_BIT], gateReg[RPCG_TWOWIRE0_BIT]}
  ) else $error("two-wire enables not on their gate bits");

  a_encoder_map: assert property (
    @(posedge mclk) disable iff (!rst_b)
    unitClkEn[6:5] == {gateReg[RPCG_ENCODER1_BIT], gateReg[RPCG_ENCODER0_BIT]}
  ) else $error("encoder enables not on their gate bits");

  a_sync_map: assert property (
    @(posedge mclk) disable iff (!rst_b)
    unitClkEn[4:3] == {gateReg[RPCG_SYNC1_BIT], gateReg[RPCG_SYNC0_BIT]}
  ) else $error("synchronous serial enables not on their gate bits");

  a_async_map: assert property (
    @(posedge mclk) disable iff (!rst_b)
    unitClkEn[2:0] == gateReg[RPCG_ASYNC2_BIT:RPCG_ASYNC0_BIT]
  ) else $error("asynchronous serial enables not on their gate bits");

  a_enable_follows: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $changed(gateReg) |-> unitClkEn == unitsOf(gateReg)
  ) else $error("unit enable does not follow gate bits");

  a_reset_cuts: assert property (
    @(posedge mclk)
    !rst_b |=> gateReg == RPCG_GATE_RESET && unitClkEn == '0
  ) else $error("reset left a unit clocked");

  a_fault_gated: assert property (
    @(posedge mclk) disable iff (!rst_b)
    |(unitAccess & ~unitClkEn) |=> unitFault && !unitGrant
  ) else $error("access to gated unit not faulted");

  a_grant_open: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (unitAccess != '0 && (unitAccess & ~unitClkEn) == '0) |=> unitGrant && !unitFault
  ) else $error("access to clocked unit faulted");

  a_quiet_units: assert property (
    @(posedge mclk) disable iff (!rst_b)
    unitAccess == '0 |=> !unitFault && !unitGrant
  ) else $error("fault or grant without an access");

  a_fault_excl: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !(unitFault && unitGrant)
  ) else $error("fault and grant raised together");

  // Clock side: enables move only while mclk is low, which is what keeps pulses whole.
  a_gate_steady: assert property (
    @(negedge mclk) disable iff (!rst_b)
    ##1 enLow == $past(unitClkEn)
  ) else $error("low-phase enable not retimed");

  a_clock_cut: assert property (
    @(negedge mclk) disable iff (!rst_b)
    unitClk == $past(unitClkEn)
  ) else $error("unit clock high phase does not match its enable");
endmodule
`default_nettype wire

//--- rtl/rpcg_pkg.sv
// Package with register map, field layout and bus carrier types of the clock gate block.
package rpcg_pkg;
  localparam logic [31:0] RPCG_GATE_OFFSET = 32'h0000_0104;
  localparam logic [31:0] RPCG_GATE_RESET = 32'h0000_0000;
  localparam logic [31:0] RPCG_GATE_WMASK = 32'h000f_5337;
  localparam int RPCG_NUM_UNITS = 13;
  localparam int RPCG_COUNTER3_BIT = 19;
  localparam int RPCG_COUNTER0_BIT = 16;
  localparam int RPCG_TWOWIRE1_BIT = 14;
  localparam int RPCG_TWOWIRE0_BIT = 12;
  localparam int RPCG_ENCODER1_BIT = 9;
  localparam int RPCG_ENCODER0_BIT = 8;
  localparam int RPCG_SYNC1_BIT = 5;
  localparam int RPCG_SYNC0_BIT = 4;
  localparam int RPCG_ASYNC2_BIT = 2;
  localparam int RPCG_ASYNC0_BIT = 0;
  localparam logic [1:0] RPCG_HTRANS_NONSEQ = 2'h2;
  localparam logic RPCG_HRESP_OKAY = 1'h0;

  typedef struct packed {
    logic active;
    logic write;
    logic hit;
  } rpcg_aphase_t;
endpackage

//--- tb/rpcg_units_model.sv
// Peripheral side model that counts the clock pulses each gated unit receives.
`timescale 1ns/1ps
`default_nettype none
module rpcg_units_model (
  input wire logic [rpcg_pkg::RPCG_NUM_UNITS-1:0] unitClk,
  output var int pulses [rpcg_pkg::RPCG_NUM_UNITS]
);
  import rpcg_pkg::*;
  int count [RPCG_NUM_UNITS] = '{default: 0};
  assign pulses = count;
  // A unit only advances on edges it really sees, so a runt or stuck clock shows as a bad count.
  for (genvar i = 0; i < RPCG_NUM_UNITS; i++) begin : g_unit
    always @(posedge unitClk[i]) count[i] <= count[i] + 1;
  end
endmodule
`default_nettype wire

//--- tb/test_rpcg_clock_gate.sv
// Self-checking bench for the run-mode clock gate register and unit clocks.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", n, e, s); end end
module test_rpcg_clock_gate;
  import rpcg_pkg::*;
  logic mclk = 0, rst_b = 0, hsel = 0, hwrite = 0;
  logic hreadyout, hresp, unitFault, unitGrant;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, model = 0, rd = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [RPCG_NUM_UNITS-1:0] unitAccess = 0, unitClkEn, unitClk, en, acc;
  int fail_count = 0, checks = 0, p0 [RPCG_NUM_UNITS], pulses [RPCG_NUM_UNITS];
  rpcg_clock_gate u_rpcg_clock_gate (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .unitAccess(unitAccess),
    .unitFault(unitFault), .unitGrant(unitGrant), .unitClkEn(unitClkEn), .unitClk(unitClk));
  rpcg_units_model u_rpcg_units_model (.unitClk(unitClk), .pulses(pulses));
  task automatic tally_and_finish();
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Called right after a rising edge; returns at the edge that ends the data phase.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int waits = 0;
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= RPCG_HTRANS_NONSEQ;
    do begin @(posedge mclk); waits++; end while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge mclk); waits++; end while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("hresp", RPCG_HRESP_OKAY, hresp)
    `CHK("bus cycles", 2, waits)
  endtask
  function automatic logic [RPCG_NUM_UNITS-1:0] units(input logic [31:0] g);
    return {g[19:16], g[14], g[12], g[9:8], g[5:4], g[2:0]};
  endfunction
  initial begin
    forever #50 mclk = ~mclk;
  end
  initial begin
    #2000000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hf6c8));
    repeat (16) @(posedge mclk);
    rst_b <= 1;
    @(posedge mclk);
    bus(0, RPCG_GATE_OFFSET, 0);
    `CHK("reset", RPCG_GATE_RESET, rd)
    for (int n = 0; n < 6; n++) begin
      // Odd passes keep reserved bits as read; even passes hit them with noise.
      model = n[0] ? (rd ^ ($urandom() & RPCG_GATE_WMASK)) : $urandom();
      bus(1, RPCG_GATE_OFFSET, model);
      bus(1, RPCG_GATE_OFFSET + 32'h4, ~model);
      bus(0, RPCG_GATE_OFFSET + 32'h4, 0);
      `CHK("unmapped", 32'h0, rd)
      bus(0, RPCG_GATE_OFFSET, 0);
      model &= RPCG_GATE_WMASK;
      `CHK("gate", model, rd)
      en = units(model);
      `CHK("enables", en, unitClkEn)
      @(negedge mclk);
      p0 = pulses;
      repeat (4) @(negedge mclk);
      for (int k = 0; k < RPCG_NUM_UNITS; k++) `CHK("pulses", en[k] ? 4 : 0, pulses[k] - p0[k])
      // One unit at a time, then none, then a random mix of units.
      for (int k = 0; k <= RPCG_NUM_UNITS + 1; k++) begin
        acc = k > RPCG_NUM_UNITS ? RPCG_NUM_UNITS'($urandom()) : RPCG_NUM_UNITS'(1) << k;
        @(posedge mclk);
        unitAccess <= acc;
        @(posedge mclk);
        unitAccess <= 0;
        @(negedge mclk);
        `CHK("fault", |(acc & ~en), unitFault)
        `CHK("grant", acc != 0 && (acc & ~en) == 0, unitGrant)
      end
      @(posedge mclk);
    end
    rst_b <= 0;
    repeat (2) @(posedge mclk);
    rst_b <= 1;
    @(posedge mclk);
    bus(0, RPCG_GATE_OFFSET, 0);
    `CHK("rereset", RPCG_GATE_RESET, rd)
    `CHK("rereset enables", RPCG_NUM_UNITS'(0), unitClkEn)
    tally_and_finish();
  end
endmodule
`default_nettype wire
